// >>> hw/dcc_top.sv
// CRC generator and DMA channel control registers behind an AHB-Lite slave.
// Assumes a transfer engine that reports per-channel activity, block completion and events.
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dcc_top (
  input  wire logic                        clock_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        hsel_i,
  input  wire logic [31:0]                 haddr_i,
  input  wire logic [1:0]                  htrans_i,
  input  wire logic                        hwrite_i,
  input  wire logic [2:0]                  hsize_i,
  input  wire logic [31:0]                 hwdata_i,
  input  wire logic                        hready_i,
  output logic      [31:0]                 hrdata_o,
  output logic                             hreadyout_o,
  output logic                             hresp_o,
  input  wire logic [dcc_pkg::NUM_CH-1:0]  start_event_i,
  input  wire logic [dcc_pkg::NUM_CH-1:0]  abort_event_i,
  input  wire logic [dcc_pkg::NUM_CH-1:0]  block_done_i,
  input  wire logic [dcc_pkg::NUM_CH-1:0]  xfer_active_i,
  input  wire logic                        crc_valid_i,
  input  wire logic [15:0]                 crc_data_i,
  output logic      [dcc_pkg::NUM_CH-1:0]  ch_grant_o,
  output logic      [dcc_pkg::NUM_CH-1:0]  ch_busy_o,
  output logic      [31:0]                 crc_result_o,
  output logic                             irq_o
);

  dcc_pkg::dcc_state_s q;
  dcc_pkg::dcc_state_s d;

  // Steps the shift-register CRC over one stream beat, most significant bit first.
  function automatic logic [31:0] lfsr_step(
    input logic [31:0] crc_in,
    input logic [31:0] taps,
    input logic [4:0]  polynomial_length,
    input logic [15:0] dat
  );
    logic [31:0] c;
    logic        fb;
    c  = crc_in;
    fb = 1'b0;
    for (int b = dcc_pkg::STREAM_W - 1; b >= 0; b--)
    begin
      fb = c[polynomial_length] ^ dat[b];
      c  = {c[30:0], 1'b0} ^ ({32{fb}} & taps);
    end
    return c;
  endfunction

  // Adds one word to the running ones-complement sum with end-around carry.
  function automatic logic [15:0] csum_add(
    input logic [15:0] sum,
    input logic [15:0] dat
  );
    logic [16:0] s;
    s = {1'b0, sum} + {1'b0, dat};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  // Forms the software view of the CRC register for the active mode.
  function automatic logic [31:0] crc_view(
    input dcc_pkg::dcc_state_s st
  );
    logic [32:0] mask;
    logic [5:0]  len;
    len  = {1'b0, st.polynomial_length} + 6'h01;
    mask = (33'h0_0000_0001 << len) - 33'h0_0000_0001;
    if (st.crc_type)
    begin
      return {16'h0000, ~st.crc[15:0]};
    end
    return st.crc & mask[31:0];
  endfunction

  // Returns the read value of a register index; unmapped words read zero.
  function automatic logic [31:0] read_word(
    input dcc_pkg::dcc_state_s st,
    input logic [5:0]          idx
  );
    logic [31:0] w;
    w = dcc_pkg::RESET_WORD;
    case ({idx, 2'b00})
      dcc_pkg::OFS_CRC_CTRL:
      begin
        w[dcc_pkg::CRC_EN_BIT]                                  = st.crc_en;
        w[dcc_pkg::CRC_TYP_BIT]                                 = st.crc_type;
        w[dcc_pkg::POLYNOMIAL_LENGTH_LSB +: dcc_pkg::POLYNOMIAL_LENGTH_W]                 = st.polynomial_length;
      end
      dcc_pkg::OFS_CRC_DATA: w = crc_view(st);
      dcc_pkg::OFS_CRC_XOR:  w = st.taps;
      dcc_pkg::OFS_INT_STAT: w[dcc_pkg::STAT_W-1:0] = st.stat;
      dcc_pkg::OFS_INT_EN:   w[dcc_pkg::STAT_W-1:0] = st.inten;
      default:
      begin
        for (int i = 0; i < dcc_pkg::NUM_CH; i++)
        begin
          if ({idx, 2'b00} == dcc_pkg::OFS_CH_BASE + 8'(4 * i))
          begin
            w[dcc_pkg::CH_BUSY_BIT]                   = st.busy[i];
            w[dcc_pkg::CH_CHNS_BIT]                   = st.chns[i];
            w[dcc_pkg::CH_EN_BIT]                     = st.en[i];
            w[dcc_pkg::CH_AED_BIT]                    = st.aed[i];
            w[dcc_pkg::CH_CHN_BIT]                    = st.chn[i];
            w[dcc_pkg::CH_AEN_BIT]                    = st.aen[i];
            w[dcc_pkg::CH_EDET_BIT]                   = st.edet[i];
            w[dcc_pkg::CH_PRI_LSB +: dcc_pkg::PRI_W]  = st.pri[i];
          end
        end
      end
    endcase
    return w;
  endfunction

  logic [dcc_pkg::NUM_CH-1:0] nb_done;
  logic [dcc_pkg::NUM_CH-1:0] req;
  logic [dcc_pkg::PRI_W-1:0]  best_pri;
  logic                       found;
  logic [dcc_pkg::STAT_W-1:0] stat_set;
  logic [dcc_pkg::STAT_W-1:0] stat_clr;
  logic [31:0]                wd;

  always_comb
  begin
    d        = q;
    nb_done  = '0;
    req      = '0;
    best_pri = '0;
    found    = 1'b0;
    stat_set = '0;
    stat_clr = '0;
    wd       = hwdata_i;

    // The CRC engine consumes one stream beat per cycle while enabled.
    if (crc_valid_i && q.crc_en)
    begin
      if (q.crc_type)
      begin
        d.crc = {16'h0000, csum_add(q.crc[15:0], crc_data_i)};
      end
      else
      begin
        d.crc = lfsr_step(q.crc, q.taps, q.polynomial_length, crc_data_i);
      end
    end

    // Data phase of the transfer taken in the previous address phase.
    d.ready = 1'b1;
    d.resp  = 1'b0;
    case (q.bus)
      dcc_pkg::DCC_BUS_WRITE:
      begin
        if (q.hit)
        begin
          case ({q.idx, 2'b00})
            dcc_pkg::OFS_CRC_CTRL:
            begin
              d.crc_en   = wd[dcc_pkg::CRC_EN_BIT];
              d.crc_type = wd[dcc_pkg::CRC_TYP_BIT];
              d.polynomial_length     = wd[dcc_pkg::POLYNOMIAL_LENGTH_LSB +: dcc_pkg::POLYNOMIAL_LENGTH_W];
            end
            dcc_pkg::OFS_CRC_DATA: d.crc = wd;
            dcc_pkg::OFS_CRC_XOR:  d.taps = wd;
            dcc_pkg::OFS_INT_CLR:  stat_clr = wd[dcc_pkg::STAT_W-1:0];
            dcc_pkg::OFS_INT_EN:   d.inten = wd[dcc_pkg::STAT_W-1:0];
            default:
            begin
              for (int i = 0; i < dcc_pkg::NUM_CH; i++)
              begin
                if ({q.idx, 2'b00} == dcc_pkg::OFS_CH_BASE + 8'(4 * i))
                begin
                  d.chns[i] = wd[dcc_pkg::CH_CHNS_BIT];
                  d.en[i]   = wd[dcc_pkg::CH_EN_BIT];
                  d.aed[i]  = wd[dcc_pkg::CH_AED_BIT];
                  d.chn[i]  = wd[dcc_pkg::CH_CHN_BIT];
                  d.aen[i]  = wd[dcc_pkg::CH_AEN_BIT];
                  d.pri[i]  = wd[dcc_pkg::CH_PRI_LSB +: dcc_pkg::PRI_W];
                end
              end
            end
          endcase
        end
      end
      dcc_pkg::DCC_BUS_READ:
      begin
        d.rdata = q.hit ? read_word(q, q.idx) : dcc_pkg::RESET_WORD;
      end
      default:
      begin
        d.rdata = q.rdata;
      end
    endcase

    // Address phase: reads take one wait state so the data comes from a flop.
    d.bus = dcc_pkg::DCC_BUS_IDLE;
    if (hsel_i && hready_i && htrans_i[1])
    begin
      d.idx = haddr_i[dcc_pkg::ADDR_MSB:dcc_pkg::ADDR_LSB];
      d.hit = (haddr_i[31:dcc_pkg::ADDR_MSB+1] == '0) && (hsize_i == 3'h2);
      if (hwrite_i)
      begin
        d.bus = dcc_pkg::DCC_BUS_WRITE;
      end
      else
      begin
        d.bus   = dcc_pkg::DCC_BUS_READ;
        d.ready = 1'b0;
      end
    end

    // Channel events, completion and chaining.
    for (int i = 0; i < dcc_pkg::NUM_CH; i++)
    begin
      if (q.chns[i])
      begin
        nb_done[i] = (i < dcc_pkg::NUM_CH - 1) ? block_done_i[(i + 1) % dcc_pkg::NUM_CH]
                                                 : 1'b0;
      end
      else
      begin
        nb_done[i] = (i > 0) ? block_done_i[(i + dcc_pkg::NUM_CH - 1) % dcc_pkg::NUM_CH]
                             : 1'b0;
      end
      if (block_done_i[i])
      begin
        stat_set[i] = 1'b1;
        d.edet[i]   = 1'b0;
        if (!q.aen[i])
        begin
          d.en[i] = 1'b0;
        end
      end
      if (q.chn[i] && nb_done[i])
      begin
        d.en[i] = 1'b1;
      end
      if (abort_event_i[i] && (q.en[i] || q.aed[i]))
      begin
        d.edet[i]                    = 1'b0;
        stat_set[dcc_pkg::NUM_CH + i] = 1'b1;
      end
      if (start_event_i[i] && (q.en[i] || q.aed[i]))
      begin
        d.edet[i] = 1'b1;
      end
      // Busy holds while the engine finishes its current transaction.
      d.busy[i] = d.en[i] || xfer_active_i[i];
      req[i]    = q.en[i] && q.edet[i] && !xfer_active_i[i];
    end

    // Highest priority requester wins; ties go to the lowest channel number.
    d.grant = '0;
    for (int i = dcc_pkg::NUM_CH - 1; i >= 0; i--)
    begin
      if (req[i] && (!found || q.pri[i] >= best_pri))
      begin
        found    = 1'b1;
        best_pri = q.pri[i];
      end
    end
    for (int i = 0; i < dcc_pkg::NUM_CH; i++)
    begin
      if (req[i] && (q.pri[i] == best_pri) && (d.grant == '0))
      begin
        d.grant[i] = 1'b1;
      end
    end

    // Sticky status: a set in the same cycle as its clear wins.
    d.stat = (q.stat & ~stat_clr) | stat_set;
    d.irq  = |(d.stat & d.inten);
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      q       <= '0;
      q.ready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign hrdata_o     = q.rdata;
  assign hreadyout_o  = q.ready;
  assign hresp_o      = q.resp;
  assign ch_grant_o   = q.grant;
  assign ch_busy_o    = q.busy;
  assign crc_result_o = q.crc;
  assign irq_o        = q.irq;

endmodule // dcc_top
`default_nettype wire

// >>> inc/dcc_pkg.sv
// Package of the CRC and channel control block: register map, field positions and state types.
// Assumes a single 100 MHz clock domain and a word-wide bus slave in front of the registers.
`default_nettype none
package dcc_pkg;
  localparam int          NUM_CH       = 4;
  localparam int          STAT_W       = 2 * NUM_CH;
  localparam int          DATA_W       = 32;
  localparam int          SUM_W        = 16;
  localparam int          STREAM_W     = 16;
  localparam int          PRI_W        = 2;
  localparam int          IDX_W        = 6;
  // Byte offsets of the registers.
  localparam logic [7:0]  OFS_CRC_CTRL = 8'h00;
  localparam logic [7:0]  OFS_CRC_DATA = 8'h04;
  localparam logic [7:0]  OFS_CRC_XOR  = 8'h08;
  localparam logic [7:0]  OFS_INT_STAT = 8'h0C;
  localparam logic [7:0]  OFS_INT_CLR  = 8'h10;
  localparam logic [7:0]  OFS_INT_EN   = 8'h14;
  localparam logic [7:0]  OFS_CH_BASE  = 8'h20;
  localparam int          ADDR_LSB     = 2;
  localparam int          ADDR_MSB     = 7;
  // Field positions of the CRC control register.
  localparam int          CRC_EN_BIT   = 7;
  localparam int          CRC_TYP_BIT  = 5;
  localparam int          POLYNOMIAL_LENGTH_LSB     = 8;
  localparam int          POLYNOMIAL_LENGTH_W       = 5;
  // Field positions of the channel control register.
  localparam int          CH_BUSY_BIT  = 15;
  localparam int          CH_CHNS_BIT  = 8;
  localparam int          CH_EN_BIT    = 7;
  localparam int          CH_AED_BIT   = 6;
  localparam int          CH_CHN_BIT   = 5;
  localparam int          CH_AEN_BIT   = 4;
  localparam int          CH_EDET_BIT  = 2;
  localparam int          CH_PRI_LSB   = 0;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_BUSY  = 2'h1;

  typedef enum logic [1:0] {
    DCC_BUS_IDLE  = 2'b00,
    DCC_BUS_WRITE = 2'b01,
    DCC_BUS_READ  = 2'b10
  } dcc_bus_e;

  typedef struct packed {
    dcc_bus_e                      bus;
    logic                          hit;
    logic [IDX_W-1:0]              idx;
    logic [DATA_W-1:0]             rdata;
    logic                          ready;
    logic                          resp;
    logic                          crc_en;
    logic                          crc_type;
    logic [POLYNOMIAL_LENGTH_W-1:0]             polynomial_length;
    logic [DATA_W-1:0]             crc;
    logic [DATA_W-1:0]             taps;
    logic [NUM_CH-1:0]             en;
    logic [NUM_CH-1:0]             aed;
    logic [NUM_CH-1:0]             chn;
    logic [NUM_CH-1:0]             aen;
    logic [NUM_CH-1:0]             edet;
    logic [NUM_CH-1:0]             chns;
    logic [NUM_CH-1:0][PRI_W-1:0]  pri;
    logic [NUM_CH-1:0]             busy;
    logic [NUM_CH-1:0]             grant;
    logic [STAT_W-1:0]             stat;
    logic [STAT_W-1:0]             inten;
    logic                          irq;
  } dcc_state_s;
endpackage
`default_nettype wire

// >>> sim/dcc_properties.sv
// Checker of the CRC and channel control block, bound to its top module.
// Assumes hready_i is fed from hreadyout_o.
`timescale 1ns/1ns
`default_nettype none
module dcc_checker (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic [3:0]  xfer_active_i,
  input wire logic        crc_valid_i,
  input wire logic [3:0]  ch_grant_o,
  input wire logic [3:0]  ch_busy_o,
  input wire logic [31:0] crc_result_o,
  input wire logic        irq_o
);
  logic take;
  logic seed_q;
  assign take = hsel_i && hready_i && htrans_i[1];
  always_ff @(posedge clock_i)
    seed_q <= take && hwrite_i && hsize_i == 3'h2 && haddr_i[7:0] == dcc_pkg::OFS_CRC_DATA;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  chk_reset_clear: assert property ($fell(sys_rst_i) |-> ch_busy_o == 4'h0
    && irq_o == 1'b0 && hrdata_o == 32'h0) else $error("state not cleared by reset");
  chk_seed_load: assert property (seed_q && hready_i |=> crc_result_o == $past(hwdata_i))
    else $error("seed not loaded");
  chk_crc_hold: assert property (!seed_q && !crc_valid_i |=> $stable(crc_result_o))
    else $error("crc changed without cause");
  chk_busy_active: assert property (xfer_active_i != 4'h0 |=>
    (ch_busy_o & $past(xfer_active_i)) == $past(xfer_active_i)) else $error("busy low");
  chk_busy_drop: assert property ((~ch_busy_o & $past(ch_busy_o) & $past(xfer_active_i))
    == 4'h0) else $error("busy dropped mid transaction");
  chk_grant_onehot: assert property ($onehot0(ch_grant_o))
    else $error("grant not one-hot");
  chk_read_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  chk_rdata_hold: assert property ($changed(hrdata_o) |-> $rose(hreadyout_o))
    else $error("read data changed outside a read");
endmodule // dcc_checker
bind dcc_top dcc_checker u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .xfer_active_i(xfer_active_i), .crc_valid_i(crc_valid_i), .ch_grant_o(ch_grant_o),
  .ch_busy_o(ch_busy_o), .crc_result_o(crc_result_o), .irq_o(irq_o));
`default_nettype wire

// >>> sim/dcc_engine_model.sv
// Transfer engine model: answers a grant with a transaction and a block completion.
// Assumes one grant at a time; slow_i stretches each transaction.
`timescale 1ns/1ns
`default_nettype none
module dcc_engine_model (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic [3:0] grant_i,
  input  wire logic       slow_i,
  output logic      [3:0] xfer_active_o,
  output logic      [3:0] block_done_o
);
  logic [3:0] sel_q;
  logic [3:0] cnt_q;
  assign xfer_active_o = (cnt_q > 4'h3) ? sel_q : 4'h0;
  always_ff @(posedge clock_i)
  begin
    block_done_o <= (cnt_q == 4'h4) ? sel_q : 4'h0;
    if (sys_rst_i)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else if (grant_i != 4'h0)
    begin
      sel_q <= grant_i;
      cnt_q <= slow_i ? 4'hA : 4'h5;
    end
  end
endmodule // dcc_engine_model
`default_nettype wire

// >>> sim/tb_top.sv
// Bench of the CRC and channel control block with an engine model.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  start = 4'h0;
  logic [3:0]  abort = 4'h0;
  logic        cvalid = 1'b0;
  logic [15:0] cdata = 16'h0;
  logic        slow = 1'b0;
  logic [31:0] seed = 32'd36019;
  logic [31:0] hrdata, cres, rd, x, t;
  logic [3:0]  grant, busy, done, active;
  logic        ready, resp, irq;
  logic [4:0]  p;
  logic [15:0] d;
  logic [1:0]  pa, pb;
  logic [31:0] c2 [3] = '{32'h20, 32'h120, 32'h0};
  int          mismatches = 0;
  int          check_count = 0;
  always #5 clock_i = ~clock_i;
  dcc_top DUT (.clock_i(clock_i), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(ready),
    .hrdata_o(hrdata), .hreadyout_o(ready), .hresp_o(resp), .start_event_i(start),
    .abort_event_i(abort), .block_done_i(done), .xfer_active_i(active), .crc_valid_i(cvalid),
    .crc_data_i(cdata), .ch_grant_o(grant), .ch_busy_o(busy), .crc_result_o(cres), .irq_o(irq));
  dcc_engine_model u_eng (.clock_i(clock_i), .sys_rst_i(rst), .grant_i(grant), .slow_i(slow),
    .xfer_active_o(active), .block_done_o(done));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] step(input logic [31:0] c, input logic [31:0] tp,
      input logic [4:0] pl, input logic [15:0] dv);
    logic fb;
    for (int i = 15; i >= 0; i--)
    begin
      fb = c[pl] ^ dv[i];
      c = (c << 1) ^ (fb ? tp : 32'h0);
    end
    return c;
  endfunction
  function automatic logic [7:0] cha(input int i);
    return dcc_pkg::OFS_CH_BASE + 8'(4 * i);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock_i); while (ready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clock_i); while (ready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [3:0] s);
    start <= s;
    @(posedge clock_i);
    start <= 4'h0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    test_done();
  end
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst <= 1'b0;
    @(posedge clock_i);
    for (int i = 0; i < 4; i++)
      rchk(cha(i), 32'h0);
    rchk(dcc_pkg::OFS_CRC_DATA, 32'h0);
    rchk(dcc_pkg::OFS_CRC_XOR, 32'h0);
    bus(8'h18, 1'b1, rnd());
    rchk(8'h18, 32'h0);
    repeat (4)
    begin
      x = rnd();
      bus(dcc_pkg::OFS_CRC_XOR, 1'b1, x);
      rchk(dcc_pkg::OFS_CRC_XOR, x);
      bus(cha(3), 1'b1, x & 32'hFFFF_FF7F);
      rchk(cha(3), x & 32'h0000_0173);
    end
    bus(cha(3), 1'b1, 32'h0);
    bus(dcc_pkg::OFS_CRC_CTRL, 1'b1, 32'h0000_00A0);
    x = rnd();
    bus(dcc_pkg::OFS_CRC_DATA, 1'b1, x);
    rchk(dcc_pkg::OFS_CRC_DATA, {16'h0, ~x[15:0]});
    for (int k = 0; k < 3; k++)
    begin
      p = (k == 0) ? 5'h1F : 5'(rnd());
      x = rnd();
      t = rnd();
      bus(dcc_pkg::OFS_CRC_CTRL, 1'b1, {19'h0, p, 8'h80});
      bus(dcc_pkg::OFS_CRC_XOR, 1'b1, t);
      bus(dcc_pkg::OFS_CRC_DATA, 1'b1, x);
      rchk(dcc_pkg::OFS_CRC_DATA, x & (32'hFFFF_FFFF >> (5'h1F - p)));
      d = 16'(rnd());
      cdata <= d;
      cvalid <= 1'b1;
      @(posedge clock_i);
      cvalid <= 1'b0;
      x = step(x, t, p, d);
      rchk(dcc_pkg::OFS_CRC_DATA, x & (32'hFFFF_FFFF >> (5'h1F - p)));
    end
    bus(cha(1), 1'b1, 32'h40);
    pulse(4'h6);
    rchk(cha(1), 32'h44);
    rchk(cha(2), 32'h0);
    abort <= 4'h2;
    @(posedge clock_i);
    abort <= 4'h0;
    rchk(cha(1), 32'h40);
    for (int k = 0; k < 3; k++)
    begin
      pa = 2'(rnd());
      pb = (k == 0) ? pa : 2'(rnd());
      slow <= k[0];
      bus(cha(0), 1'b1, 32'h80 | pa);
      bus(cha(1), 1'b1, 32'h90 | pb);
      bus(cha(2), 1'b1, c2[k]);
      pulse(4'h3);
      do @(posedge clock_i); while (grant == 4'h0);
      chk(grant, (pb > pa) ? 4'h2 : 4'h1);
      do bus(dcc_pkg::OFS_INT_STAT, 1'b0, 32'h0); while (rd[1:0] !== 2'h3);
      rchk(dcc_pkg::OFS_INT_STAT, (k == 0) ? 32'h23 : 32'h3);
      rchk(cha(0), 32'h0 | pa);
      rchk(cha(1), 32'h8090 | pb);
      rchk(cha(2), (k == 0) ? 32'h80A0 : c2[k]);
      bus(dcc_pkg::OFS_INT_EN, 1'b1, (k == 1) ? 32'h0 : 32'h3);
      rchk(dcc_pkg::OFS_INT_EN, (k == 1) ? 32'h0 : 32'h3);
      chk(irq, k != 1);
      bus(dcc_pkg::OFS_INT_CLR, 1'b1, 32'hFF);
      rchk(dcc_pkg::OFS_INT_STAT, 32'h0);
      chk(irq, 1'b0);
    end
    slow <= 1'b1;
    bus(cha(0), 1'b1, 32'h80);
    pulse(4'h1);
    do @(posedge clock_i); while (active[0] !== 1'b1);
    bus(cha(0), 1'b1, 32'h0);
    do bus(cha(0), 1'b0, 32'h0); while (rd[15] !== 1'b0);
    chk(active, 4'h0);
    chk(resp, 1'b0);
    chk(cres & 32'h0, 32'h0);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
